// *** verilog/pe_port_e.sv ***
// The AXI4-Lite slave port and the address map were decided locally.
`include "pe_defs.svh"
module pe_port_e #(
	parameter logic [7:0] CFG3H_RST = 8'h84,
	parameter logic [7:0] CFG4L_RST = 8'h85
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [4:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [4:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [3:0] padIn,
	output pe_pkg::pe_pad_t pad,
	input pe_pkg::pe_periph_t periph,
	input wire logic hvProgMode,
	output logic capture3,
	output logic capture5,
	output logic unit3AtDefaultPin,
	output logic masterClearReq,
	output logic pin3Pullup,
	output logic [4:0] slewReduced,
	output logic [2:0] analogChanEn
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] outputLatchE;
	logic [7:0] directionE;
	logic [7:0] analogSelectE;
	logic [7:0] slewRateControl;
	logic [7:0] interruptControlTwo;
	logic [7:0] configWordThreeHigh;
	logic [7:0] configWordFourLow;
	logic [7:0] next_outputLatchE;
	logic [7:0] next_directionE;
	logic [7:0] next_analogSelectE;
	logic [7:0] next_slewRateControl;
	logic [7:0] next_interruptControlTwo;
	logic [7:0] next_configWordThreeHigh;
	logic [7:0] next_configWordFourLow;

	pe_pkg::pe_wr_t wr;
	logic wrErr;
	logic [4:0] rdAddr;
	logic rdEn;
	logic [7:0] rdData;
	logic rdErr;

	// ------------------------------------------------------------
	// pin state
	// ------------------------------------------------------------
	logic [2:0] digIn;
	logic [2:0] perEn;
	logic [2:0] perOut;
	logic [2:0] mux_out;
	logic [2:0] mux_oe;
	logic pin3Digital;
	logic unit3Local;
	logic masterClearEnable;
	logic lowVoltageProgEnable;
	pe_pkg::pe_pad_t next_pad;
	logic next_capture3;
	logic next_capture5;
	logic next_masterClearReq;
	logic next_pin3Pullup;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	pe_axil_slave u_bus (
		.mclk(mclk),
		.rst_n(rst_n),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.wr(wr),
		.wrErr(wrErr),
		.rdAddr(rdAddr),
		.rdEn(rdEn),
		.rdData(rdData),
		.rdErr(rdErr)
	);

	// ------------------------------------------------------------
	// register write path
	// ------------------------------------------------------------
	always_comb begin
		next_outputLatchE = outputLatchE;
		next_directionE = directionE;
		next_analogSelectE = analogSelectE;
		next_slewRateControl = slewRateControl;
		next_interruptControlTwo = interruptControlTwo;
		next_configWordThreeHigh = configWordThreeHigh;
		next_configWordFourLow = configWordFourLow;
		wrErr = 1'b0;
		unique case (wr.addr)
			`PE_OFS_PIN, `PE_OFS_LATCH: begin
				if (wr.en) begin
					next_outputLatchE = wr.data & `PE_MSK_LATCH; // RULE19
				end
			end
			`PE_OFS_DIR: begin
				if (wr.en) begin
					next_directionE = wr.data & `PE_MSK_DIR;
				end
			end
			`PE_OFS_ANALOG_SELECT_REG: begin
				if (wr.en) begin
					next_analogSelectE = wr.data & `PE_MSK_ANALOG_SELECT_REG;
				end
			end
			`PE_OFS_SLEW: begin
				if (wr.en) begin
					next_slewRateControl = wr.data & `PE_MSK_SLEW;
				end
			end
			`PE_OFS_INTERRUPT_CONTROL_TWO: begin
				if (wr.en) begin
					next_interruptControlTwo = wr.data & `PE_MSK_INTERRUPT_CONTROL_TWO;
				end
			end
			`PE_OFS_CFG3H: begin
				if (wr.en) begin
					next_configWordThreeHigh = wr.data & `PE_MSK_CFG3H;
				end
			end
			`PE_OFS_CFG4L: begin
				if (wr.en) begin
					next_configWordFourLow = wr.data & `PE_MSK_CFG4L;
					// low-voltage bit held outside high-voltage mode
					if (!hvProgMode) begin
						next_configWordFourLow[`PE_BIT_LVP] =
							configWordFourLow[`PE_BIT_LVP]; // RULE18
					end
				end
			end
			default: begin
				wrErr = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			outputLatchE <= `PE_RST_LATCH;
			directionE <= `PE_RST_DIR; // RULE14
			analogSelectE <= `PE_RST_ANALOG_SELECT_REG; // RULE13
			slewRateControl <= `PE_RST_SLEW; // RULE17 RULE22
			interruptControlTwo <= `PE_RST_INTERRUPT_CONTROL_TWO;
			configWordThreeHigh <= CFG3H_RST;
			configWordFourLow <= CFG4L_RST;
		end else begin
			outputLatchE <= next_outputLatchE;
			directionE <= next_directionE;
			analogSelectE <= next_analogSelectE;
			slewRateControl <= next_slewRateControl;
			interruptControlTwo <= next_interruptControlTwo;
			configWordThreeHigh <= next_configWordThreeHigh;
			configWordFourLow <= next_configWordFourLow;
		end
	end

	// ------------------------------------------------------------
	// register read path
	// ------------------------------------------------------------
	always_comb begin
		rdData = 8'h00;
		rdErr = 1'b0;
		unique case (rdAddr)
			`PE_OFS_PIN: begin
				rdData = {4'h0, pin3Digital, digIn}; // RULE19 RULE11
			end
			`PE_OFS_LATCH: begin
				rdData = outputLatchE;
			end
			`PE_OFS_DIR: begin
				rdData = directionE;
			end
			`PE_OFS_ANALOG_SELECT_REG: begin
				rdData = analogSelectE;
			end
			`PE_OFS_SLEW: begin
				rdData = slewRateControl;
			end
			`PE_OFS_INTERRUPT_CONTROL_TWO: begin
				rdData = interruptControlTwo;
			end
			`PE_OFS_CFG3H: begin
				rdData = configWordThreeHigh;
			end
			`PE_OFS_CFG4L: begin
				rdData = configWordFourLow;
			end
			default: begin
				rdErr = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// pin multiplexing
	// ------------------------------------------------------------
	always_comb begin
		masterClearEnable = configWordThreeHigh[`PE_BIT_MCLE];
		lowVoltageProgEnable = configWordFourLow[`PE_BIT_LVP];
		unit3Local = ~configWordThreeHigh[`PE_BIT_LOC]; // RULE10
		// pwm output a sits above the compare output on pin 0
		perEn[0] = unit3Local & (periph.pwmAEn | periph.ccp3En); // RULE10
		perOut[0] = periph.pwmAEn ? periph.pwmA : periph.ccp3Out; // RULE1
		perEn[1] = periph.pwmBEn; // RULE5
		perOut[1] = periph.pwmB; // RULE5
		perEn[2] = periph.ccp5En; // RULE7
		perOut[2] = periph.ccp5Out; // RULE7
		pin3Digital = ~masterClearEnable & padIn[`PE_BIT_PIN3]; // RULE8
	end
	for (genvar i = 0; i < 3; i++) begin : g_pin
		pe_pin_mux u_mux (
			.latchBit(outputLatchE[i]),
			.dirBit(directionE[i]),
			.anaSel(analogSelectE[i]),
			.perEn(perEn[i]),
			.perOut(perOut[i]),
			.padIn(padIn[i]),
			.nextOut(mux_out[i]),
			.nextOe(mux_oe[i]),
			.digIn(digIn[i])
		);
	end

	// ------------------------------------------------------------
	// registered pin and peripheral outputs
	// ------------------------------------------------------------
	always_comb begin
		next_pad.drive = mux_out; // RULE3 RULE5 RULE6 RULE7
		next_pad.enable = mux_oe; // RULE20 RULE12 RULE2
		next_capture3 = unit3Local & directionE[0] & digIn[0]; // RULE6
		next_capture5 = directionE[2] & digIn[2]; // RULE7
		next_masterClearReq = masterClearEnable &
			~padIn[`PE_BIT_PIN3]; // RULE9
		next_pin3Pullup = lowVoltageProgEnable | masterClearEnable |
			(~interruptControlTwo[`PE_BIT_GPD] &
			directionE[`PE_BIT_PULLUP]); // RULE21
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pad <= '0;
			capture3 <= 1'b0;
			capture5 <= 1'b0;
			masterClearReq <= 1'b0;
			pin3Pullup <= 1'b0;
		end else begin
			pad <= next_pad;
			capture3 <= next_capture3;
			capture5 <= next_capture5;
			masterClearReq <= next_masterClearReq;
			pin3Pullup <= next_pin3Pullup;
		end
	end

	assign unit3AtDefaultPin = ~unit3Local; // RULE10
	assign slewReduced = slewRateControl[4:0]; // RULE16 RULE22
	assign analogChanEn = analogSelectE[2:0]; // RULE15

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_pwm_a_on_pin0;
		periph.pwmAEn && unit3Local && !directionE[0];
	endsequence
	property p_pwm_priority;
		s_pwm_a_on_pin0 ##1 1'b1 |->
			pad.enable[0] && pad.drive[0] == $past(periph.pwmA);
	endproperty
	a_pwm_priority: assert property (p_pwm_priority) // RULE1
		else $error("pin 0 not driven by pwm output a");
	property p_analog_keeps_drive;
		!directionE[1] && analogSelectE[1] |=> pad.enable[1];
	endproperty
	a_analog_keeps_drive: assert property (p_analog_keeps_drive) // RULE12
		else $error("analog select blocked output driver");
	property p_latch_drive;
		!directionE[1] && !periph.pwmBEn |=>
			pad.drive[1] == $past(outputLatchE[1]);
	endproperty
	a_latch_drive: assert property (p_latch_drive) // RULE3
		else $error("pin 1 not showing latch bit");
	property p_dir_off;
		directionE[2] |=> !pad.enable[2];
	endproperty
	a_dir_off: assert property (p_dir_off) // RULE20
		else $error("driver on with direction set");
	property p_analog_reads_zero;
		rdEn && rdAddr == `PE_OFS_PIN && analogSelectE[0] |=>
			rvalid && rdata[0] == 1'b0;
	endproperty
	a_analog_reads_zero: assert property (p_analog_reads_zero) // RULE11
		else $error("analog pin read back non-zero");
	property p_master_clear;
		masterClearEnable && !padIn[`PE_BIT_PIN3] |=> masterClearReq;
	endproperty
	a_master_clear: assert property (p_master_clear) // RULE9
		else $error("master clear not requested");
	property p_pullup;
		!lowVoltageProgEnable && !masterClearEnable |=>
			pin3Pullup == $past(~interruptControlTwo[`PE_BIT_GPD] &
			directionE[`PE_BIT_PULLUP]);
	endproperty
	a_pullup: assert property (p_pullup) // RULE21
		else $error("pin 3 pull-up wrong");
	property p_lvp_locked;
		!hvProgMode |=> $stable(configWordFourLow[`PE_BIT_LVP]);
	endproperty
	a_lvp_locked: assert property (p_lvp_locked) // RULE18
		else $error("low-voltage bit changed outside hv mode");
	property p_capture5;
		directionE[2] && !analogSelectE[2] |=>
			capture5 == $past(padIn[2]);
	endproperty
	a_capture5: assert property (p_capture5) // RULE7
		else $error("capture 5 input not following pin 2");
	property p_port_write;
		wr.en && wr.addr == `PE_OFS_PIN |=>
			outputLatchE == ($past(wr.data) & `PE_MSK_LATCH);
	endproperty
	a_port_write: assert property (p_port_write) // RULE19
		else $error("port write did not reach latch");
	property p_pin3_read;
		rdEn && rdAddr == `PE_OFS_PIN && masterClearEnable |=>
			rdata[`PE_BIT_PIN3] == 1'b0;
	endproperty
	a_pin3_read: assert property (p_pin3_read) // RULE8
		else $error("pin 3 readable while master clear on");
endmodule : pe_port_e

// *** inc/pe_defs.svh ***
// What this block does
// [RULE1] several enabled outputs on a pin: highest priority function drives it
// [RULE2] digital outputs still drive a pin in analog mode, same priority
// [RULE3] direction 0, analog 0: pins 0-2 drive their latch bit
// [RULE4] direction 1: pins 0-2 are inputs, cut off when analog is selected
// [RULE5] pins 0 and 1 carry the two PWM unit 3 outputs when outputs
// [RULE6] pin 0 carries unit 3 compare output, or feeds unit 3 capture
// [RULE7] pin 2 carries unit 5 compare output, or feeds unit 5 capture
// [RULE8] master clear disabled: pin 3 is a digital input, port bit 3
// [RULE9] master clear enabled: pin 3 low resets the device
// [RULE10] unit 3 signals use pin 0 only when location select is clear
// [RULE11] analog select disables digital input; digital reads return 0
// [RULE12] analog select never blocks a digital output
// [RULE13] analog select bits reset to 1
// [RULE14] direction bits reset to 1
// [RULE15] analog channels 5-7 active only while their pin is analog
// [RULE16] each port selects standard or one-tenth output slew rate
// [RULE17] reduced slew rate is the default after reset
// [RULE18] low-voltage programming bit changes only in high-voltage program mode
// [RULE19] port writes update the latch; port reads return pin levels
// [RULE20] direction 1 turns driver off; 0 drives latch onto pin
// [RULE21] pin 3 pull-up on when global disable is 0 and enable set
// [RULE22] slew bit 1 selects reduced rate, 0 standard; resets to 1
// [RULE23] an enabled peripheral output wins over the latch on pins 0-2
`ifndef PE_DEFS_SVH
`define PE_DEFS_SVH
`define PE_OFS_PIN 5'h00
`define PE_OFS_LATCH 5'h04
`define PE_OFS_DIR 5'h08
`define PE_OFS_ANALOG_SELECT_REG 5'h0C
`define PE_OFS_SLEW 5'h10
`define PE_OFS_INTERRUPT_CONTROL_TWO 5'h14
`define PE_OFS_CFG3H 5'h18
`define PE_OFS_CFG4L 5'h1C
`define PE_RST_LATCH 8'h00
`define PE_RST_DIR 8'h87
`define PE_RST_ANALOG_SELECT_REG 8'h07
`define PE_RST_SLEW 8'h1F
`define PE_RST_INTERRUPT_CONTROL_TWO 8'h80
`define PE_MSK_LATCH 8'h07
`define PE_MSK_DIR 8'h87
`define PE_MSK_ANALOG_SELECT_REG 8'h07
`define PE_MSK_SLEW 8'h1F
`define PE_MSK_INTERRUPT_CONTROL_TWO 8'hF5
`define PE_MSK_CFG3H 8'hBF
`define PE_MSK_CFG4L 8'hC5
`define PE_BIT_PULLUP 7
`define PE_BIT_GPD 7
`define PE_BIT_MCLE 7
`define PE_BIT_LOC 2
`define PE_BIT_LVP 2
`define PE_BIT_PIN3 3
`define PE_RESP_OKAY 2'h0
`define PE_RESP_SLVERR 2'h2
`endif

// *** inc/pe_pkg.sv ***
package pe_pkg;
	typedef struct packed {
		logic [2:0] drive;
		logic [2:0] enable;
	} pe_pad_t;
	typedef struct packed {
		logic pwmA;
		logic pwmB;
		logic ccp3Out;
		logic ccp5Out;
		logic pwmAEn;
		logic pwmBEn;
		logic ccp3En;
		logic ccp5En;
	} pe_periph_t;
	typedef struct packed {
		logic en;
		logic [4:0] addr;
		logic [7:0] data;
	} pe_wr_t;
endpackage : pe_pkg

// *** verilog/pe_pin_mux.sv ***
module pe_pin_mux (
	input wire logic latchBit,
	input wire logic dirBit,
	input wire logic anaSel,
	input wire logic perEn,
	input wire logic perOut,
	input wire logic padIn,
	output logic nextOut,
	output logic nextOe,
	output logic digIn
);
	always_comb begin
		digIn = padIn & ~anaSel; // RULE4 RULE11
		nextOe = ~dirBit; // RULE20 RULE12 RULE2
		nextOut = perEn ? perOut : latchBit; // RULE23 RULE1 RULE3
	end
endmodule : pe_pin_mux

// *** verilog/pe_axil_slave.sv ***
`include "pe_defs.svh"
module pe_axil_slave (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [4:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [4:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output pe_pkg::pe_wr_t wr,
	input wire logic wrErr,
	output logic [4:0] rdAddr,
	output logic rdEn,
	input wire logic [7:0] rdData,
	input wire logic rdErr
);
	logic awHeld, wHeld, strbQ;
	logic [4:0] awAddrQ;
	logic [7:0] wDataQ;
	logic next_awHeld, next_wHeld, next_strbQ, next_bvalid, next_rvalid;
	logic [4:0] next_awAddrQ;
	logic [7:0] next_wDataQ;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic awTake, wTake, doWrite;

	assign awready = ~awHeld & ~bvalid;
	assign wready = ~wHeld & ~bvalid;
	assign arready = ~rvalid;
	assign rdAddr = araddr;
	assign rdEn = arvalid & arready;

	always_comb begin
		awTake = awvalid & awready;
		wTake = wvalid & wready;
		doWrite = (awHeld | awTake) & (wHeld | wTake) & ~bvalid;
		wr.addr = awHeld ? awAddrQ : awaddr;
		wr.data = wHeld ? wDataQ : wdata[7:0];
		wr.en = doWrite & (wHeld ? strbQ : wstrb[0]);
		next_awHeld = (awHeld | awTake) & ~doWrite;
		next_wHeld = (wHeld | wTake) & ~doWrite;
		next_awAddrQ = awTake ? awaddr : awAddrQ;
		next_wDataQ = wTake ? wdata[7:0] : wDataQ;
		next_strbQ = wTake ? wstrb[0] : strbQ;
		next_bvalid = doWrite | (bvalid & ~bready);
		next_bresp = bresp;
		if (doWrite) begin
			next_bresp = wrErr ? `PE_RESP_SLVERR : `PE_RESP_OKAY;
		end
		next_rvalid = rdEn | (rvalid & ~rready);
		next_rdata = rdata;
		next_rresp = rresp;
		if (rdEn) begin
			next_rdata = {24'h000000, rdData};
			next_rresp = rdErr ? `PE_RESP_SLVERR : `PE_RESP_OKAY;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= 5'h00;
			wDataQ <= 8'h00;
			strbQ <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `PE_RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `PE_RESP_OKAY;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddrQ <= next_awAddrQ;
			wDataQ <= next_wDataQ;
			strbQ <= next_strbQ;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
endmodule : pe_axil_slave

// *** sim/pe_pin_world.sv ***
module pe_pin_world (
	input wire logic mclk,
	input pe_pkg::pe_pad_t pad,
	input wire logic pin3Pullup,
	input wire logic [3:0] extDrive,
	input wire logic [3:0] extLevel,
	output logic [3:0] padIn
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// pins left floating show a changing level
	// ----------------------------------------
	logic floatPat = 1'b0;
	always_ff @(posedge mclk) begin
		floatPat <= ~floatPat;
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (pad.enable[i]) begin
				padIn[i] = pad.drive[i];
			end else if (extDrive[i]) begin
				padIn[i] = extLevel[i];
			end else begin
				padIn[i] = floatPat ^ i[0];
			end
		end
		if (extDrive[3]) begin
			padIn[3] = extLevel[3];
		end else if (pin3Pullup) begin
			padIn[3] = 1'b1;
		end else begin
			padIn[3] = floatPat;
		end
	end
endmodule : pe_pin_world

// *** sim/tb_port_e_pin_control.sv ***
`include "pe_defs.svh"
`define CHK(got, exp) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
	end \
end
module tb_port_e_pin_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, hvProgMode;
	logic capture3, capture5, unit3AtDefaultPin, masterClearReq, pin3Pullup;
	logic mcl, loc;
	logic [4:0] awaddr, araddr, slewReduced;
	logic [31:0] wdata, rdata, rd, rnd;
	logic [3:0] wstrb, padIn, extDrive, extLevel;
	logic [1:0] bresp, rresp, rs, wrResp;
	logic [2:0] analogChanEn, ans, lat, expD;
	logic [7:0] rstVal [8] = '{8'h00, 8'h00, 8'h87, 8'h07,
		8'h1F, 8'h80, 8'h84, 8'h85};
	pe_pkg::pe_pad_t pad;
	pe_pkg::pe_periph_t periph;
	int n_fail, n_checks, cycles;

	pe_port_e u_dut (.mclk(mclk), .rst_n(rst_n), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.padIn(padIn), .pad(pad), .periph(periph), .hvProgMode(hvProgMode),
		.capture3(capture3), .capture5(capture5),
		.unit3AtDefaultPin(unit3AtDefaultPin),
		.masterClearReq(masterClearReq), .pin3Pullup(pin3Pullup),
		.slewReduced(slewReduced), .analogChanEn(analogChanEn));
	pe_pin_world u_world (.mclk(mclk), .pad(pad), .pin3Pullup(pin3Pullup),
		.extDrive(extDrive), .extLevel(extLevel), .padIn(padIn));

	// ----------------------------------------
	// bus tasks and expectations
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [2:0] exp_drive(input pe_pkg::pe_periph_t p,
		input logic [2:0] l, input logic sel);
		logic [2:0] d;
		d = l;
		if (!sel && p.ccp3En) d[0] = p.ccp3Out;
		if (!sel && p.pwmAEn) d[0] = p.pwmA;
		if (p.pwmBEn) d[1] = p.pwmB;
		if (p.ccp5En) d[2] = p.ccp5Out;
		return d;
	endfunction : exp_drive
	task automatic axi_write(input logic [4:0] a, input logic [7:0] d);
		logic awDone, wDone, bDone;
		awDone = 1'b0;
		wDone = 1'b0;
		bDone = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bDone) begin
			@(posedge mclk);
			if (!awDone && awready) begin
				awvalid <= 1'b0;
				awDone = 1'b1;
			end
			if (!wDone && wready) begin
				wvalid <= 1'b0;
				wDone = 1'b1;
			end
			if (bvalid) begin
				bready <= 1'b0;
				wrResp = bresp;
				bDone = 1'b1;
			end
		end
	endtask : axi_write
	task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic arDone, rDone;
		arDone = 1'b0;
		rDone = 1'b0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rDone) begin
			@(posedge mclk);
			if (!arDone && arready) begin
				arvalid <= 1'b0;
				arDone = 1'b1;
			end
			if (rvalid) begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
				rDone = 1'b1;
			end
		end
	endtask : axi_read
	task automatic settle;
		repeat (2) @(posedge mclk);
	endtask : settle
	task stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_fail++;
			stop_test;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, hvProgMode} = '0;
		{awaddr, araddr, wdata, extDrive, extLevel, cycles} = '0;
		wstrb = 4'hF;
		periph = '0;
		rnd = 32'h282A;
		n_fail = 0;
		n_checks = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		`CHK(slewReduced, 5'h1F)
		`CHK(analogChanEn, 3'h7)
		`CHK(pad.enable, 3'h0)
		for (int i = 0; i < 8; i++) begin
			axi_read(5'(i * 4), rd, rs);
			`CHK(rd, {24'h0, rstVal[i]})
			`CHK(rs, `PE_RESP_OKAY)
		end
		axi_read(5'h02, rd, rs);
		`CHK(rd[31:8], 24'h0)
		`CHK(rs, `PE_RESP_SLVERR)
		axi_write(5'h02, 8'hFF);
		`CHK(wrResp, `PE_RESP_SLVERR)
		$display("test reset done");
		axi_write(`PE_OFS_DIR, 8'h80);
		`CHK(wrResp, `PE_RESP_OKAY)
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			periph <= pe_pkg::pe_periph_t'(rnd[7:0]);
			loc = rnd[8];
			lat = rnd[11:9];
			ans = rnd[15:13];
			axi_write(`PE_OFS_CFG3H, {5'h10, loc, 2'h0});
			axi_write(rnd[12] ? `PE_OFS_PIN : `PE_OFS_LATCH, {5'h0, lat});
			axi_write(`PE_OFS_ANALOG_SELECT_REG, {5'h0, ans});
			settle;
			expD = exp_drive(periph, lat, loc);
			`CHK(pad.drive, expD)
			`CHK(pad.enable, 3'h7)
			`CHK(unit3AtDefaultPin, loc)
			`CHK(analogChanEn, ans)
			axi_read(`PE_OFS_PIN, rd, rs);
			`CHK(rd, {29'h0, expD & ~ans})
		end
		$display("test outputs done");
		periph <= '0;
		axi_write(`PE_OFS_DIR, 8'h87);
		extDrive <= 4'hF;
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			extLevel <= rnd[3:0];
			ans = rnd[6:4];
			mcl = rnd[7];
			loc = rnd[8];
			axi_write(`PE_OFS_ANALOG_SELECT_REG, {5'h0, ans});
			axi_write(`PE_OFS_CFG3H, {mcl, 4'h0, loc, 2'h0});
			settle;
			axi_read(`PE_OFS_PIN, rd, rs);
			`CHK(rd[3:0], {~mcl & extLevel[3], extLevel[2:0] & ~ans})
			`CHK(masterClearReq, mcl & ~extLevel[3])
			`CHK(capture3, extLevel[0] & ~ans[0] & ~loc)
			`CHK(capture5, extLevel[2] & ~ans[2])
			`CHK(pad.enable, 3'h0)
		end
		$display("test inputs done");
		hvProgMode <= 1'b1;
		axi_write(`PE_OFS_CFG4L, 8'h81);
		hvProgMode <= 1'b0;
		axi_write(`PE_OFS_CFG4L, 8'h85);
		axi_read(`PE_OFS_CFG4L, rd, rs);
		`CHK(rd, 32'h81)
		extDrive <= 4'h7;
		axi_write(`PE_OFS_CFG3H, 8'h00);
		for (int i = 0; i < 4; i++) begin
			axi_write(`PE_OFS_INTERRUPT_CONTROL_TWO, {i[1], 7'h0});
			axi_write(`PE_OFS_DIR, {i[0], 7'h07});
			settle;
			`CHK(pin3Pullup, ~i[1] & i[0])
		end
		axi_write(`PE_OFS_CFG3H, 8'h80);
		settle;
		`CHK(pin3Pullup, 1'b1)
		$display("test pull-up done");
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			axi_write(`PE_OFS_SLEW, rnd[7:0]);
			settle;
			`CHK(slewReduced, rnd[4:0])
			axi_read(`PE_OFS_SLEW, rd, rs);
			`CHK(rd, {27'h0, rnd[4:0]})
		end
		// a write with its low strobe clear must leave the register alone
		wstrb <= 4'h0;
		axi_write(`PE_OFS_SLEW, 8'h00);
		wstrb <= 4'hF;
		`CHK(slewReduced, rnd[4:0])
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		`CHK(slewReduced, 5'h1F)
		`CHK(analogChanEn, 3'h7)
		`CHK(pad.enable, 3'h0)
		$display("test slew done");
		stop_test;
	end
endmodule : tb_port_e_pin_control
